// ==== design/codec_control_registers.sv ====
// Control register bank of the voice codec, written over control frames.
// What this block does
// - Register one bit 7 shows FIR overflow.
// - Register one bit 6 enables mic receive amp.
// - Mic receive amp forces aux input selection.
// - Register one bit 4 picks aux input.
// - Software reset bit clears itself after reset.
// - Register one bit 2 bypasses both FIR filters.
// - Register one bit 1 enables mic transmit amps.
// - Register one bit 0 selects 16-bit DAC.
// - Divider code zero means thirty-two, else code.
// - Over four cascaded, odd divide skews duty.
// - Few cascaded, bypassed, odd multiple skews duty.
// - Register three top bits select test mode.
// - Register three bit 5 enables continuous transfer.
// - Flag pin follows bit 3 or indicator.
// - Register three bit 0 selects 16-bit ADC.
// - Register four top nibble sets ADC gain.
// - Frame holds address, rw, register, content.
`timescale 1ns/1ps
`default_nettype none
`include "codec_ctrl_defines.svh"
module codec_control_registers
  import codec_ctrl_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_ce,
  input  wire logic [2:0]  i_dev_addr,
  input  wire logic        i_sclk,
  input  wire logic        i_frame_sync,
  input  wire logic        i_din,
  input  wire logic        i_fir_overflow,
  input  wire logic        i_sec_comm,
  output var  logic [7:0]  o_read_data,
  output var  logic        o_read_valid,
  output var  logic        o_soft_reset,
  output var  logic        o_flag_pin,
  output var  codec_cfg_s  o_cfg
);
  typedef struct packed {
    logic [2:0]  tog_sync;
    logic [2:0]  sec_sync;
    logic [2:0]  ovf_sync;
    logic        tog_seen;
    logic        sec_level;
    logic        ovf_level;
    logic [7:0]  path;
    logic [7:0]  clkdiv;
    logic [7:0]  loop;
    logic [7:0]  gain;
    logic        ovf_flag;
    logic        soft_reset;
    logic [7:0]  read_data;
    logic        read_valid;
    logic        flag_pin;
    codec_cfg_s  cfg;
  } bank_state_s;

  bank_state_s cur;
  bank_state_s next_cur;
  logic [15:0] rx_word;
  logic        rx_toggle;
  ctrl_frame_s frame;
  logic        frame_new;
  logic        frame_mine;
  logic [7:0]  rd_mux;

  // Frames are shifted on the link clock and handed over by a toggle.
  ctrl_frame_rx u_rx (
    .i_sclk       (i_sclk),
    .i_frame_sync (i_frame_sync),
    .i_din        (i_din),
    .o_word       (rx_word),
    .o_toggle     (rx_toggle)
  );

  // Frame fields; the word is stable by the time the toggle is seen.
  assign frame = ctrl_frame_s'({rx_word[15:13], rx_word[12],
                                rx_word[11:9], rx_word[7:0]});
  // A toggle change counts once the second and third stages agree.
  assign frame_new  = (cur.tog_sync[2] == cur.tog_sync[1]) &&
                      (cur.tog_sync[2] != cur.tog_seen);
  assign frame_mine = frame_new && (frame.dev_addr == i_dev_addr);

  // Read-back view; the reserved bit and the self-clearing bit show zero.
  always_comb begin
    rd_mux = 8'h00;
    unique case (frame.reg_num)
      `REG_PATH: begin
        rd_mux = cur.path;
        rd_mux[`PATH_OVF]      = cur.ovf_flag;
        rd_mux[`PATH_SW_RESET] = 1'b0;
      end
      `REG_CLKDIV: begin
        rd_mux = cur.clkdiv;
        rd_mux[`CLKDIV_RESERVED] = 1'b0;
      end
      `REG_LOOP: rd_mux = cur.loop;
      `REG_GAIN: rd_mux = cur.gain;
      default:   rd_mux = 8'h00;
    endcase
  end

  // Next state: synchronisers, frame decode, register writes, derived config.
  always_comb begin
    next_cur = cur;
    next_cur.tog_sync = {cur.tog_sync[1:0], rx_toggle};
    next_cur.sec_sync = {cur.sec_sync[1:0], i_sec_comm};
    next_cur.ovf_sync = {cur.ovf_sync[1:0], i_fir_overflow};
    if (cur.sec_sync[2] == cur.sec_sync[1]) begin
      next_cur.sec_level = cur.sec_sync[2];
    end
    if (cur.ovf_sync[2] == cur.ovf_sync[1]) begin
      next_cur.ovf_level = cur.ovf_sync[2];
    end
    next_cur.read_valid = 1'b0;
    next_cur.soft_reset = 1'b0;
    if (frame_new) begin
      next_cur.tog_seen = cur.tog_sync[2];
    end
    // The flag is live status: it tracks the overflow indication.
    next_cur.ovf_flag = cur.ovf_level;
    if (frame_mine && !frame.read) begin
      unique case (frame.reg_num)
        `REG_PATH: begin
          next_cur.path = frame.content;
          next_cur.path[`PATH_OVF]      = 1'b0;
          next_cur.path[`PATH_SW_RESET] = 1'b0;
          next_cur.soft_reset = frame.content[`PATH_SW_RESET];
        end
        `REG_CLKDIV: begin
          next_cur.clkdiv = frame.content;
          next_cur.clkdiv[`CLKDIV_RESERVED] = 1'b0;
        end
        `REG_LOOP: next_cur.loop = frame.content;
        `REG_GAIN: next_cur.gain = frame.content;
        default: next_cur.path = cur.path; // Register 0 is no operation.
      endcase
    end else if (frame_mine && frame.read) begin
      next_cur.read_data  = rd_mux;
      next_cur.read_valid = 1'b1;
    end
    // A software reset returns the bank to defaults.
    if (cur.soft_reset) begin
      next_cur.path   = `PATH_RESET;
      next_cur.clkdiv = `CLKDIV_RESET;
      next_cur.loop   = `LOOP_RESET;
      next_cur.gain   = `GAIN_RESET;
    end
    // Flag pin source.
    next_cur.flag_pin = cur.loop[`LOOP_FLAG_SRC] ?
                        cur.loop[`LOOP_FLAG_VAL] : cur.sec_level;
    // Decoded configuration, registered so every output is a flop.
    next_cur.cfg.mic_rx_en = cur.path[`PATH_MIC_RX];
    next_cur.cfg.aa_bypass = cur.path[`PATH_AA_BYPASS];
    next_cur.cfg.aux_selected = cur.path[`PATH_AUX_SEL] |
                                cur.path[`PATH_MIC_RX];
    // One bit bypasses both decimation and interpolation filters.
    next_cur.cfg.fir_bypass = cur.path[`PATH_FIR_BYPASS];
    next_cur.cfg.mic_tx_en  = cur.path[`PATH_MIC_TX];
    next_cur.cfg.dac16      = cur.path[`PATH_DAC16];
    next_cur.cfg.low_power  = cur.clkdiv[`CLKDIV_LOW_POWER];
    next_cur.cfg.mod_stop   = cur.clkdiv[`CLKDIV_MOD_STOP];
    // Duty-cycle skew for odd dividers is accepted by the clock generator,
    // so nonzero codes are passed through unchanged.
    next_cur.cfg.divide_value = (cur.clkdiv[4:0] == 5'h00) ?
                                `DIV_ZERO_AS : {1'b0, cur.clkdiv[4:0]};
    next_cur.cfg.test_mode =
      test_mode_e'(cur.loop[`LOOP_MODE_HI:`LOOP_MODE_LO]);
    next_cur.cfg.continuous = cur.loop[`LOOP_CONT];
    next_cur.cfg.power_mode =
      power_mode_e'(cur.loop[`LOOP_PWR_HI:`LOOP_PWR_LO]);
    next_cur.cfg.adc16    = cur.loop[`LOOP_ADC16];
    next_cur.cfg.adc_gain = cur.gain[`GAIN_ADC_HI:`GAIN_ADC_LO];
    next_cur.cfg.adc_mute =
      (cur.gain[`GAIN_ADC_HI:`GAIN_ADC_LO] == `GAIN_MUTE);
  end

  // Synchronous reset puts every field at a constant; enable freezes all.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cur <= '0;
    end else if (i_ce) begin
      cur <= next_cur;
    end
  end

  assign o_read_data  = cur.read_data;
  assign o_read_valid = cur.read_valid;
  assign o_soft_reset = cur.soft_reset;
  assign o_flag_pin   = cur.flag_pin;
  assign o_cfg        = cur.cfg;
endmodule // codec_control_registers
`default_nettype wire

// ==== design/codec_ctrl_defines.svh ====
// Offsets, field positions, reset values and frame length of the control bank.
`ifndef CODEC_CTRL_DEFINES_SVH
`define CODEC_CTRL_DEFINES_SVH
`define FRAME_BITS        16
`define DEV_ADDR_HI       15
`define DEV_ADDR_LO       13
`define RW_BIT            12
`define REG_NUM_HI        11
`define REG_NUM_LO        9
`define REG_NOP           3'h0
`define REG_PATH          3'h1
`define REG_CLKDIV        3'h2
`define REG_LOOP          3'h3
`define REG_GAIN          3'h4
`define PATH_OVF          7
`define PATH_MIC_RX       6
`define PATH_AA_BYPASS    5
`define PATH_AUX_SEL      4
`define PATH_SW_RESET     3
`define PATH_FIR_BYPASS   2
`define PATH_MIC_TX       1
`define PATH_DAC16        0
`define CLKDIV_LOW_POWER  7
`define CLKDIV_MOD_STOP   6
`define CLKDIV_RESERVED   5
`define LOOP_MODE_HI      7
`define LOOP_MODE_LO      6
`define LOOP_CONT         5
`define LOOP_FLAG_SRC     4
`define LOOP_FLAG_VAL     3
`define LOOP_PWR_HI       2
`define LOOP_PWR_LO       1
`define LOOP_ADC16        0
`define GAIN_ADC_HI       7
`define GAIN_ADC_LO       4
`define PATH_RESET        8'h00
`define CLKDIV_RESET      8'h00
`define LOOP_RESET        8'h00
`define GAIN_RESET        8'h00
`define GAIN_MUTE         4'hf
`define DIV_ZERO_AS       6'h20
`endif

// ==== design/codec_ctrl_pkg.sv ====
// Types shared by the control bank and its frame receiver.
package codec_ctrl_pkg;
  typedef enum logic [1:0] {
    MODE_NORMAL  = 2'h0,
    MODE_ALOOP   = 2'h1,
    MODE_DLOOP   = 2'h2,
    MODE_MONITOR = 2'h3
  } test_mode_e;
  typedef enum logic [1:0] {
    PWR_NORMAL = 2'h0,
    PWR_NO_ADC = 2'h1,
    PWR_NO_DAC = 2'h2,
    PWR_DOWN   = 2'h3
  } power_mode_e;
  typedef struct packed {
    logic [2:0] dev_addr;
    logic       read;
    logic [2:0] reg_num;
    logic [7:0] content;
  } ctrl_frame_s;
  typedef struct packed {
    logic       mic_rx_en;
    logic       aa_bypass;
    logic       aux_selected;
    logic       fir_bypass;
    logic       mic_tx_en;
    logic       dac16;
    logic       low_power;
    logic       mod_stop;
    logic [5:0] divide_value;
    test_mode_e  test_mode;
    logic        continuous;
    power_mode_e power_mode;
    logic        adc16;
    logic [3:0]  adc_gain;
    logic        adc_mute;
  } codec_cfg_s;
endpackage

// ==== design/ctrl_frame_rx.sv ====
// Link-clock shifter that gathers one control frame and hands it across.
`timescale 1ns/1ps
`default_nettype none
`include "codec_ctrl_defines.svh"
module ctrl_frame_rx
  import codec_ctrl_pkg::*;
(
  input  wire logic              i_sclk,
  input  wire logic              i_frame_sync,
  input  wire logic              i_din,
  output var  logic [15:0]       o_word,
  output var  logic              o_toggle
);
  typedef struct packed {
    logic [15:0] shift;
    logic [4:0]  count;
    logic [15:0] word;
    logic        toggle;
  } rx_state_s;
  // There is no reset on this side, so a power-up value is needed.
  // Otherwise the bit count and the toggle would start unknown and never
  // settle, because the link clock only runs inside frames.
  rx_state_s cur = '0;
  rx_state_s next_cur;

  // Bits arrive MSB first while sync is high; the word is loaded on the same edge that the
  // toggle flips, and the far domain reads it only after the toggle has passed its synchroniser.
  always_comb begin
    next_cur = cur;
    if (i_frame_sync) begin
      next_cur.shift = {cur.shift[14:0], i_din};
      if (cur.count == 5'(`FRAME_BITS - 1)) begin
        next_cur.word   = {cur.shift[14:0], i_din};
        next_cur.toggle = ~cur.toggle;
        next_cur.count  = 5'h00;
      end else begin
        next_cur.count = cur.count + 5'h01;
      end
    end else begin
      next_cur.count = 5'h00; // A short frame is dropped, not merged.
    end
  end

  // The link clock may stop between frames; no reset is needed here because
  // the receiving side compares toggles relative to its own captured copy.
  always_ff @(posedge i_sclk) begin
    cur <= next_cur;
  end

  assign o_word   = cur.word;
  assign o_toggle = cur.toggle;
endmodule // ctrl_frame_rx
`default_nettype wire

// ==== testbench/codec_control_registers_tb.sv ====
// Self-checking bench for the codec control register bank.
`timescale 1ns/1ps
`default_nettype none
module codec_control_registers_tb;
  import codec_ctrl_pkg::*;
  logic       i_clk = 1'b0;
  logic       i_sys_rst = 1'b1;
  logic       i_ce = 1'b1;
  logic [2:0] dev = 3'h2;
  logic       ovf = 1'b0;
  logic       sec = 1'b0;
  logic       sclk, fs, din, rvalid, srst, flag;
  logic [7:0] rdata, d;
  codec_cfg_s cfg;
  logic [7:0] expq[$];
  int         error_cnt = 0;
  int         checked = 0;
  int         cycles = 0;
  always #5 i_clk = ~i_clk;
  codec_control_registers i_codec_control_registers (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_dev_addr(dev),
    .i_sclk(sclk), .i_frame_sync(fs), .i_din(din), .i_fir_overflow(ovf),
    .i_sec_comm(sec), .o_read_data(rdata), .o_read_valid(rvalid),
    .o_soft_reset(srst), .o_flag_pin(flag), .o_cfg(cfg));
  host_dsp_model i_host_dsp_model (.o_sclk(sclk), .o_frame_sync(fs),
    .o_din(din));
  task automatic check(input string nm, input logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // One frame, then enough idle for the crossing and the answer.
  task automatic xfer(logic [2:0] a, logic rd, logic [2:0] r, logic [7:0] v,
                      logic [7:0] e);
    i_host_dsp_model.send({a, rd, r, 1'b0, v});
    if (rd && a == dev) expq.push_back(e);
    repeat (12) @(negedge i_clk);
  endtask
  // Read answers are matched against the oldest note in the queue.
  always @(negedge i_clk) begin
    if (rvalid === 1'b1) begin
      if (expq.size() == 0) check("spare read", 8'h00, 8'hff);
      else check("read data", expq.pop_front(), rdata);
    end
  end
  // Hang guard: a full run needs far fewer cycles than this.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(6));
    repeat (6) @(negedge i_clk);
    i_sys_rst = 1'b0;
    xfer(dev, 1'b0, 3'h0, 8'h00, 8'h00);
    for (int r = 1; r <= 4; r++) xfer(dev, 1'b1, 3'(r), 8'h00, 8'h00);
    check("divide", 8'h20, {2'h0, cfg.divide_value});
    $display("reset values done");
    // Bit 3 of register one is kept clear so the loop never resets.
    for (int i = 0; i < 12; i++) begin
      d = 8'($urandom);
      if (i % 4 == 0) d[3] = 1'b0;
      xfer(dev, 1'b0, 3'(i % 4 + 1), d, 8'h00);
      // Decoded outputs must follow the written fields.
      case (i % 4)
        0: check("path cfg",
                 {2'h0, d[6], d[5], d[4] | d[6], d[2], d[1], d[0]},
                 {2'h0, cfg.mic_rx_en, cfg.aa_bypass, cfg.aux_selected,
                  cfg.fir_bypass, cfg.mic_tx_en, cfg.dac16});
        1: check("clkdiv cfg",
                 {d[7:6], (d[4:0] == 5'h00) ? 6'h20 : {1'b0, d[4:0]}},
                 {cfg.low_power, cfg.mod_stop, cfg.divide_value});
        2: check("loop cfg", {6'h0, d[5], d[0]},
                 {6'h0, cfg.continuous, cfg.adc16});
        default: check("gain cfg", {3'h0, d[7:4] == 4'hf, d[7:4]},
                       {3'h0, cfg.adc_mute, cfg.adc_gain});
      endcase
      xfer(dev, 1'b1, 3'(i % 4 + 1), 8'h00, (i % 4 == 0) ? d & 8'h77 :
           (i % 4 == 1) ? d & 8'hdf : d);
    end
    $display("random access done");
    foreach (d[i]) if (i < 3) begin
      xfer(dev, 1'b0, 3'h2, 8'(i * 15 + i / 2), 8'h00);
      check("divide", (i == 0) ? 8'h20 : 8'(i * 15 + i / 2),
            {2'h0, cfg.divide_value});
    end
    for (int m = 0; m < 4; m++) begin
      xfer(dev, 1'b0, 3'h3, {2'(m), 3'h0, 2'(m), 1'b0}, 8'h00);
      check("mode", 8'(m), {6'h0, cfg.test_mode});
      check("power", 8'(m), {6'h0, cfg.power_mode});
    end
    $display("modes done");
    sec = 1'b1;
    xfer(dev, 1'b0, 3'h3, 8'h00, 8'h00);
    check("flag", 8'h01, {7'h0, flag});
    xfer(dev, 1'b0, 3'h3, 8'h10, 8'h00);
    check("flag", 8'h00, {7'h0, flag});
    xfer(dev, 1'b0, 3'h3, 8'h18, 8'h00);
    check("flag", 8'h01, {7'h0, flag});
    sec = 1'b0;
    $display("flag done");
    ovf = 1'b1;
    xfer(dev, 1'b0, 3'h1, 8'h42, 8'h00);
    check("aux", 8'h01, {7'h0, cfg.aux_selected});
    xfer(dev, 1'b1, 3'h1, 8'h00, 8'hc2);
    ovf = 1'b0;
    xfer(dev ^ 3'h1, 1'b0, 3'h3, 8'hff, 8'h00);
    xfer(dev, 1'b1, 3'h3, 8'h00, 8'h18);
    xfer(dev, 1'b1, 3'h6, 8'h00, 8'h00);
    $display("refusals done");
    xfer(dev, 1'b0, 3'h1, 8'h08, 8'h00);
    xfer(dev, 1'b1, 3'h1, 8'h00, 8'h00);
    xfer(dev, 1'b1, 3'h3, 8'h00, 8'h00);
    i_ce = 1'b0;
    repeat (5) @(negedge i_clk);
    i_ce = 1'b1;
    $display("soft reset done");
    repeat (10) @(negedge i_clk);
    print_verdict();
  end
endmodule // codec_control_registers_tb
`default_nettype wire

// ==== testbench/codec_ctrl_checker.sv ====
// Assertion checker for the codec control register bank.
`timescale 1ns/1ps
`default_nettype none
module codec_ctrl_checker
  import codec_ctrl_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_ce,
  input wire logic       o_read_valid,
  input wire logic       o_soft_reset,
  input wire codec_cfg_s o_cfg
);
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  // State of the bank once a soft reset has landed.
  sequence cleared;
    !o_cfg.mic_rx_en && o_cfg.power_mode == PWR_NORMAL &&
    o_cfg.divide_value == 6'h20;
  endsequence
  a_aux_forced: assert property (
    o_cfg.mic_rx_en |-> o_cfg.aux_selected) else $error("aux not forced");
  a_div_range: assert property (
    !$past(i_sys_rst) && !$past(i_sys_rst, 2) |->
    o_cfg.divide_value != 6'h00 && o_cfg.divide_value <= 6'h20)
    else $error("divide value out of range");
  a_mute_code: assert property (
    o_cfg.adc_mute == (o_cfg.adc_gain == 4'hf)) else $error("mute decode");
  a_rv_pulse: assert property (
    o_read_valid |=> !o_read_valid) else $error("read valid too long");
  a_sr_pulse: assert property (
    o_soft_reset |=> !o_soft_reset) else $error("soft reset too long");
  a_sr_clears: assert property (
    o_soft_reset |-> ##[1:3] cleared) else $error("soft reset kept state");
  a_reset_quiet: assert property (
    disable iff (1'b0) i_sys_rst |=> !o_read_valid && o_cfg == '0)
    else $error("outputs active in reset");
  // Clock enable low must freeze the decoded configuration.
  a_ce_freeze: assert property (
    !i_ce |=> $stable(o_cfg)) else $error("config moved while frozen");
endmodule // codec_ctrl_checker
bind codec_control_registers codec_ctrl_checker i_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
  .o_read_valid(o_read_valid), .o_soft_reset(o_soft_reset), .o_cfg(o_cfg));
`default_nettype wire

// ==== testbench/host_dsp_model.sv ====
// Host processor model that sends control frames over the link.
`timescale 1ns/1ps
`default_nettype none
module host_dsp_model (
  output var logic o_sclk,
  output var logic o_frame_sync,
  output var logic o_din
);
  initial begin
    o_sclk = 1'b0;
    o_frame_sync = 1'b0;
    o_din = 1'b0;
  end
  // Link clock runs only inside a frame, so idle time shows no edges.
  task automatic send(input logic [15:0] word);
    for (int i = 15; i >= 0; i--) begin
      o_frame_sync = 1'b1;
      o_din = word[i];
      #16 o_sclk = 1'b1;
      #16 o_sclk = 1'b0;
    end
    o_frame_sync = 1'b0;
    o_din = ~o_din; // Released line shows the inverse, not stale data.
  endtask
endmodule // host_dsp_model
`default_nettype wire
